/* include/ebm_pkg.sv */
/*
 Constants for the external bus and processor mode block: mode register bit
 positions, reset values, evaluation-mode special addresses, status codes.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ebm_pkg;
    localparam int MODE_BIT = 0;
    localparam int ONE_BIT = 1;
    localparam int WAIT_BIT = 2;
    localparam logic [7:0] MODE_REG_RESET = 8'h02;
    localparam logic [23:0] P4_DATA_ADDR = 24'h00000A;
    localparam logic [23:0] P4_DIR_ADDR = 24'h00000C;
    localparam logic [1:0] CODE_IDLE = 2'h0;
    localparam logic [1:0] CODE_HOLD = 2'h1;
    localparam logic [1:0] CODE_BUSY = 2'h2;
    localparam logic [1:0] STRETCH_CYCLES = 2'h2;
    localparam logic [1:0] NOWAIT_CYCLES = 2'h1;
    typedef enum logic [2:0] {EBM_IDLE, EBM_ADDR, EBM_DATA, EBM_HOLD_IN, EBM_HOLD,
        EBM_HOLD_OUT} ebm_state_t;
endpackage : ebm_pkg

/* rtl/ebm_lane_mux.sv */
/*
 Shared-pin multiplexer for one byte lane: address while the strobe is high,
 data while it is low. Assumes the caller decides whether the lane carries data.
*/
`timescale 1ns/1ps
`default_nettype none
module ebm_lane_mux #(
    parameter int W = 8
) (
    // Selection
    input wire logic strobe_low,
    input wire logic data_lane,
    // Values
    input wire logic [W-1:0] addr,
    input wire logic [W-1:0] data,
    output logic [W-1:0] pin
);
    // Data only shows while the strobe is low on a data-carrying lane
    assign pin = (strobe_low && data_lane) ? data : addr;
endmodule : ebm_lane_mux
`default_nettype wire

/* rtl/ebm_bus_if.sv */
/*
 External bus interface and processor mode logic of a 16-bit controller.
 Assumes a single 20 MHz clock standing in for the phase clock; the CPU core
 raises one-cycle requests and waits for done; pins are split into in/out/oe.
*/
// Functional notes
// - Mode register bit 0 picks microprocessor or evaluation mode.
// - Width pin high gives an 8-bit external data bus.
// - Width pin low gives a 16-bit external data bus.
// - Internal memory accesses always use a 16-bit path.
// - Wait bit zero doubles the strobe low time for external accesses.
// - Reset clears the wait bit, stretched timing first.
// - Internal accesses use no-wait timing regardless of the wait bit.
// - Leaving reset with normal strap enters microprocessor mode.
// - Upper pins: address, then odd data on 16-bit; address only on 8-bit.
// - Lower pins: address, then even data, or both lanes on 8-bit.
// - Internal reads ignore data on the external pins.
// - Read/write high for reads, low for writes.
// - High lane select for odd, low for even, both for word.
// - Address latch strobe high passes address, low holds it.
// - Hold request taken only at a falling phase edge with bus idle.
// - Hold code first, bus floats one cycle later.
// - Leaving hold, bus driven again one cycle after code changes.
// - Ready low freezes the phase clock and bus, clock output runs.
// - Evaluation mode: upper pins always address then odd data; the code puts odd data there on writes only.
// - Evaluation mode: port-four addresses are 16-bit internal timing.
// - Evaluation mode: port-four bits output debug status, bit 7 input; the code drives bit 7 low as an output under port4_oe.
// - Width flag shows data-length flag, or index flag when used.
// - Valid-operand high on data buffer access and first opcode byte.
// - Valid-opcode high while reading opcode from queue.
`timescale 1ns/1ps
`default_nettype none
module ebm_bus_if (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_b,
    // Straps and configuration
    input wire logic mode_strap_pin,
    input wire logic width_pin,
    input wire logic mode_wr,
    input wire logic [7:0] mode_wdata,
    output logic [7:0] mode_reg,
    // CPU request side
    input wire logic req,
    input wire logic req_write,
    input wire logic req_internal,
    input wire logic [23:0] req_addr,
    input wire logic [1:0] req_bytes,
    input wire logic [15:0] req_wdata,
    output logic [15:0] rdata,
    output logic done,
    output logic bus_busy,
    // Phase clock
    output logic phase_clk,
    output logic clk_out,
    // Multiplexed bus pins
    output logic [7:0] addr_lo,
    output logic addr_lo_oe,
    input wire logic [7:0] upper_in,
    output logic [7:0] upper_out,
    output logic upper_oe,
    input wire logic [7:0] lower_in,
    output logic [7:0] lower_out,
    output logic lower_oe,
    output logic strobe_n,
    output logic addr_latch_en,
    output logic rd_wr,
    output logic high_lane_sel_n,
    output logic low_lane_sel_n,
    output logic ctl_oe,
    // Hold and ready
    input wire logic hold_req_n,
    input wire logic ready,
    output logic cycle_code_0,
    output logic cycle_code_1,
    // Evaluation debug status
    input wire logic flag_m,
    input wire logic flag_x,
    input wire logic using_x,
    input wire logic cpu_queue_flush,
    input wire logic cpu_data_access,
    input wire logic cpu_first_opcode,
    input wire logic cpu_opcode_read,
    input wire logic debug_ctl_in,
    output logic [7:3] port4_out,
    output logic port4_oe,
    output logic debug_ctl
);
    ebm_pkg::ebm_state_t state;
    ebm_pkg::ebm_state_t next_state;
    logic [1:0] wait_cnt;
    logic second_byte;
    logic [23:0] addr;
    logic [15:0] wdata;
    logic [1:0] bytes;
    logic is_write;
    logic is_internal;
    logic width16;
    logic [1:0] strobe_len;
    logic [1:0] code;
    logic float_bus;

    // Mode selection and special addresses
    wire eval_mode = mode_reg[ebm_pkg::MODE_BIT];
    wire wait_off = mode_reg[ebm_pkg::WAIT_BIT];
    wire p4_hit = (req_addr == ebm_pkg::P4_DATA_ADDR) || (req_addr == ebm_pkg::P4_DIR_ADDR);
    wire as_internal = req_internal || (eval_mode && p4_hit);
    // Width 16 for internal or width pin low; 8 when high
    wire req_w16 = as_internal || !width_pin;
    // Stretch only external accesses with the wait bit clear
    wire [1:0] req_len = (as_internal || wait_off) ? ebm_pkg::NOWAIT_CYCLES
                                                  : ebm_pkg::STRETCH_CYCLES;
    // Phase clock frozen low while ready is low; clk_out keeps running
    wire phase_run = ready;
    wire hold_take = !hold_req_n && (state == ebm_pkg::EBM_IDLE) && phase_run && !req;
    wire in_data = (state == ebm_pkg::EBM_DATA);
    wire last_beat = in_data && (wait_cnt == 2'h1) && phase_run;
    wire need_second = !width16 && (bytes == 2'h3) && !second_byte;

    assign phase_clk = clk & phase_run;
    assign clk_out = clk;
    assign bus_busy = (state != ebm_pkg::EBM_IDLE);

    // Mode register: reset leaves microprocessor mode and wait bit clear
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            mode_reg <= ebm_pkg::MODE_REG_RESET;
        end else if (mode_wr) begin
            mode_reg <= mode_wdata | ebm_pkg::MODE_REG_RESET;
        end
    end

    // Strap at 2Vcc enables only the port-four debug outputs and debug_ctl, not eval_mode; modelled as strap pin high
    logic strap_eval;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strap_eval <= 1'b0;
        end else begin
            strap_eval <= mode_strap_pin;
        end
    end

    // Bus sequencer
    always_comb begin
        next_state = state;
        unique case (state)
            ebm_pkg::EBM_IDLE: begin
                if (hold_take) next_state = ebm_pkg::EBM_HOLD_IN;
                else if (req) next_state = ebm_pkg::EBM_ADDR;
            end
            ebm_pkg::EBM_ADDR: begin
                if (phase_run) next_state = ebm_pkg::EBM_DATA;
            end
            ebm_pkg::EBM_DATA: begin
                if (last_beat) next_state = need_second ? ebm_pkg::EBM_ADDR : ebm_pkg::EBM_IDLE;
            end
            ebm_pkg::EBM_HOLD_IN: next_state = ebm_pkg::EBM_HOLD;
            ebm_pkg::EBM_HOLD: begin
                if (hold_req_n) next_state = ebm_pkg::EBM_HOLD_OUT;
            end
            ebm_pkg::EBM_HOLD_OUT: next_state = ebm_pkg::EBM_IDLE;
            default: next_state = ebm_pkg::EBM_IDLE;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            state <= ebm_pkg::EBM_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Capture the request; second byte of an 8-bit word bumps the address
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            addr <= 24'h000000;
            wdata <= 16'h0000;
            bytes <= 2'h0;
            is_write <= 1'b0;
            is_internal <= 1'b0;
            width16 <= 1'b1;
            strobe_len <= ebm_pkg::NOWAIT_CYCLES;
            second_byte <= 1'b0;
        end else if (state == ebm_pkg::EBM_IDLE && req && !hold_take) begin
            addr <= req_addr;
            wdata <= req_wdata;
            bytes <= req_bytes;
            is_write <= req_write;
            is_internal <= as_internal;
            width16 <= req_w16;
            strobe_len <= req_len;
            second_byte <= 1'b0;
        end else if (last_beat && need_second) begin
            addr <= addr + 24'h000001;
            second_byte <= 1'b1;
        end
    end

    // Strobe low-phase counter
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            wait_cnt <= 2'h0;
        end else if (state == ebm_pkg::EBM_ADDR && phase_run) begin
            wait_cnt <= strobe_len;
        end else if (in_data && phase_run && wait_cnt != 2'h0) begin
            wait_cnt <= wait_cnt - 2'h1;
        end
    end

    // Read data capture; internal reads never sample the pins
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rdata <= 16'h0000;
            done <= 1'b0;
        end else begin
            done <= last_beat && !need_second;
            if (last_beat && !is_write && !is_internal) begin
                if (width16) begin
                    rdata <= {upper_in, lower_in};
                end else if (addr[0]) begin
                    rdata[15:8] <= lower_in;
                end else begin
                    rdata[7:0] <= lower_in;
                end
            end
        end
    end

    // Strobes: address latch open in the address phase only
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            strobe_n <= 1'b1;
            addr_latch_en <= 1'b0;
        end else begin
            strobe_n <= !(next_state == ebm_pkg::EBM_DATA);
            addr_latch_en <= (next_state == ebm_pkg::EBM_ADDR);
        end
    end

    // Status code and delayed float: code leads the float by one cycle
    assign code = (state == ebm_pkg::EBM_HOLD_IN || state == ebm_pkg::EBM_HOLD)
                  ? ebm_pkg::CODE_HOLD
                  : (bus_busy ? ebm_pkg::CODE_BUSY : ebm_pkg::CODE_IDLE);
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            cycle_code_0 <= 1'b0;
            cycle_code_1 <= 1'b0;
            float_bus <= 1'b0;
        end else begin
            cycle_code_0 <= code[0];
            cycle_code_1 <= code[1];
            // Float stays through the release state so the code leads the drive by one cycle
            float_bus <= (state == ebm_pkg::EBM_HOLD) ||
                         (state == ebm_pkg::EBM_HOLD_OUT);
        end
    end

    // Lane data: odd byte on upper pins, even on lower; 8-bit uses lower only outside evaluation mode
    wire odd_sel = !width16 && (second_byte || addr[0]);
    wire [7:0] lower_data = odd_sel ? wdata[15:8] : wdata[7:0];
    wire upper_data_lane = width16 || eval_mode;
    wire strobe_low = !strobe_n;
    wire drive_data = strobe_low && is_write;

    ebm_lane_mux #(.W(8)) u_upper (
        .strobe_low(strobe_low),
        .data_lane(upper_data_lane && is_write),
        .addr(addr[15:8]),
        .data(wdata[15:8]),
        .pin(upper_out)
    );

    ebm_lane_mux #(.W(8)) u_lower (
        .strobe_low(strobe_low),
        .data_lane(is_write),
        .addr(addr[23:16]),
        .data(lower_data),
        .pin(lower_out)
    );

    assign addr_lo = addr[7:0];
    assign addr_lo_oe = !float_bus;
    assign ctl_oe = !float_bus;
    assign lower_oe = !float_bus && (strobe_n || drive_data);
    assign upper_oe = !float_bus && (strobe_n || (drive_data && upper_data_lane));
    assign rd_wr = !(bus_busy && is_write);

    // Lane selects from address parity and transfer size
    wire word_xfer = width16 && bytes == 2'h3;
    assign high_lane_sel_n = !(bus_busy && (word_xfer || odd_sel || (width16 && addr[0])));
    assign low_lane_sel_n = !(bus_busy && (word_xfer || (!odd_sel && !addr[0])));

    // Debug status on port four in evaluation mode
    wire width_flag_out = using_x ? flag_x : flag_m;
    wire queue_flush = cpu_queue_flush;
    wire valid_operand_cycle = cpu_data_access || cpu_first_opcode;
    wire valid_opcode_fetch = cpu_opcode_read;
    wire any_eval = eval_mode || strap_eval;
    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            port4_out <= 5'h00;
        end else begin
            port4_out <= {1'b0, valid_opcode_fetch, valid_operand_cycle, queue_flush,
                          width_flag_out};
        end
    end
    assign port4_oe = any_eval;
    assign debug_ctl = any_eval && debug_ctl_in;

    // Checks
    a_hold_float_lag: assert property (@(posedge clk) disable iff (!rst_b)
        state == ebm_pkg::EBM_HOLD_IN |=> !float_bus ##1 float_bus) else $error("float late");
    a_release_drive: assert property (@(posedge clk) disable iff (!rst_b)
        state == ebm_pkg::EBM_HOLD_OUT |=> float_bus ##1 !float_bus)
        else $error("release drive timing");
    a_hold_only_idle: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(state == ebm_pkg::EBM_HOLD_IN) |-> $past(state) == ebm_pkg::EBM_IDLE
        && $past(ready)) else $error("hold taken mid bus");
    a_ready_freeze: assert property (@(posedge clk) disable iff (!rst_b)
        !ready && in_data |=> $stable(wait_cnt)) else $error("moved while not ready");
    a_stretch_len: assert property (@(posedge clk) disable iff (!rst_b)
        state == ebm_pkg::EBM_ADDR && ready && !is_internal && !wait_off
        |=> wait_cnt == 2'h2) else $error("no stretch");
    a_internal_fast: assert property (@(posedge clk) disable iff (!rst_b)
        state == ebm_pkg::EBM_ADDR && ready && is_internal |=> wait_cnt == 2'h1)
        else $error("internal waited");
    a_rw_level: assert property (@(posedge clk) disable iff (!rst_b)
        in_data && !is_write |-> rd_wr) else $error("read drove low");
    a_word_lanes: assert property (@(posedge clk) disable iff (!rst_b)
        in_data && word_xfer |-> !high_lane_sel_n && !low_lane_sel_n)
        else $error("word lanes");
    a_reset_mode: assert property (@(posedge clk) disable iff (!rst_b)
        $rose(rst_b) |-> !eval_mode && !wait_off) else $error("reset mode");
endmodule : ebm_bus_if
`default_nettype wire

/* test/ebm_mem_model.sv */
/*
 External memory on the shared pins: a byte array indexed by the low address pins.
 Assumes the bench ties byte_bus to the width pin and sets the wait-state count.
*/
`timescale 1ns/1ps
`default_nettype none
module ebm_mem_model (
    // Clock and strobes
    input wire logic clk,
    input wire logic strobe_n,
    input wire logic addr_latch_en,
    input wire logic rd_wr,
    input wire logic ctl_oe,
    input wire logic high_lane_sel_n,
    input wire logic low_lane_sel_n,
    // Shared pins
    input wire logic [7:0] addr_lo,
    input wire logic [7:0] upper_out,
    input wire logic [7:0] lower_out,
    output logic [7:0] upper_in,
    output logic [7:0] lower_in,
    // Setup and wait states
    input wire logic byte_bus,
    input wire logic [3:0] slow,
    output logic ready
);
    logic [7:0] mem [256];
    logic [7:0] lat;
    logic [7:0] noise = 8'h00;
    logic [3:0] rcnt = 4'h0;
    logic sq = 1'h1;
    logic drv;
    // Address latch is open while its strobe is high
    always @* if (addr_latch_en === 1'h1) lat = addr_lo;
    assign drv = strobe_n === 1'h0 && rd_wr === 1'h1;
    // Released lines toggle every cycle so a stale value never looks valid
    assign lower_in = !drv ? noise : byte_bus ? mem[lat] : mem[{lat[7:1], 1'h0}];
    assign upper_in = (drv && !byte_bus) ? mem[{lat[7:1], 1'h1}] : ~noise;
    initial for (int i = 0; i < 256; i++) mem[i] = i[7:0] ^ 8'h5A;
    // Writes land while the strobe is low
    always @(posedge clk) begin
        noise <= noise + 8'h3B;
        if (strobe_n === 1'h0 && rd_wr === 1'h0 && ctl_oe === 1'h1) begin
            if (byte_bus) mem[lat] <= lower_out;
            if (!byte_bus && !low_lane_sel_n) mem[{lat[7:1], 1'h0}] <= lower_out;
            if (!byte_bus && !high_lane_sel_n) mem[{lat[7:1], 1'h1}] <= upper_out;
        end
    end
    // Slow memory pulls ready low on the falling edge, so the gated clock stays clean
    always @(negedge clk) begin
        if (strobe_n === 1'h0 && sq && slow != 4'h0) rcnt <= slow;
        else if (rcnt != 4'h0) rcnt <= rcnt - 4'h1;
        sq <= strobe_n;
    end
    assign ready = rcnt == 4'h0;
endmodule : ebm_mem_model
`default_nettype wire

/* test/tb.sv */
/*
 Self-checking bench for the external bus block with a memory model on the pins.
 Assumes the design and the memory model share one 20 MHz clock.
*/
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic clk = 1'h0, rst_b = 1'h0, mode_strap_pin = 1'h0, width_pin = 1'h0;
    logic mode_wr = 1'h0, req = 1'h0, req_write = 1'h0, req_internal = 1'h0;
    logic hold_req_n = 1'h1, flag_m = 1'h0, flag_x = 1'h0, using_x = 1'h0;
    logic cpu_queue_flush = 1'h0, cpu_data_access = 1'h0, cpu_first_opcode = 1'h0;
    logic cpu_opcode_read = 1'h0, debug_ctl_in = 1'h0, exp_wr = 1'h0;
    logic [7:0] mode_wdata = 8'h02;
    logic [23:0] req_addr = 24'h0;
    logic [1:0] req_bytes = 2'h3;
    logic [15:0] req_wdata = 16'h0, wd = 16'h0;
    logic [3:0] slow = 4'h0;
    logic [7:0] mode_reg, addr_lo, upper_in, upper_out, lower_in, lower_out;
    logic [15:0] rdata;
    logic [7:3] port4_out;
    logic done, bus_busy, phase_clk, clk_out, addr_lo_oe, upper_oe, lower_oe, strobe_n;
    logic addr_latch_en, rd_wr, high_lane_sel_n, low_lane_sel_n, ctl_oe, ready;
    logic cycle_code_0, cycle_code_1, port4_oe, debug_ctl;
    int miscompares = 0, n_checks = 0, seed = 32'h9A89056C, lat, lat_int, low_w, lowc = 0;
    logic [15:0] expq [$];
    logic [7:0] shadow [256];
    ebm_bus_if i_dut (.*);
    ebm_mem_model i_mem (.byte_bus(width_pin), .*);
    always #25 clk = ~clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic close_out;
        $display("checks=%0d mismatches=%0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : close_out
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    // One request, held for a single edge; a read with push set notes its expected word
    task automatic access(input logic w, input logic in, input logic [7:0] a,
        input logic [1:0] b, input logic push);
        int i;
        exp_wr = w;
        {req, req_write, req_internal, req_addr, req_bytes, req_wdata} = {1'h1, w, in,
            16'h0, a, b, wd};
        if (push) expq.push_back({shadow[a + 8'h01], shadow[a]});
        if (w) {shadow[a + 8'h01], shadow[a]} = wd;
        for (i = 1; i < 200 && done !== 1'h1; i++) begin
            step(1);
            req = 1'h0;
        end
        lat = i;
        if (done !== 1'h1) begin
            miscompares++;
            close_out();
        end
        step(1);
    endtask : access
    task automatic wmode(input logic [7:0] v);
        {mode_wdata, mode_wr} = {v, 1'h1};
        step(1);
        mode_wr = 1'h0;
        step(1);
        chk(mode_reg, v);
    endtask : wmode
    task automatic wait_code(input logic hold);
        for (int i = 0; i < 20 && (({cycle_code_1, cycle_code_0} === 2'h1) != hold); i++) step(1);
        if (({cycle_code_1, cycle_code_0} === 2'h1) != hold) begin
            miscompares++;
            close_out();
        end
    endtask : wait_code
    // Read data is compared in the cycle its done pulse stands
    always @(negedge clk)
        if (done === 1'h1 && expq.size() > 0) chk(rdata, expq.pop_front());
    // Strobe width and pin roles while an external access holds the strobe low
    always @(negedge clk) begin
        if (strobe_n === 1'h0) lowc++;
        else if (lowc > 0) {low_w, lowc} = {lowc, 0};
        if (strobe_n === 1'h0 && !width_pin && !req_internal && ready)
            chk({rd_wr, high_lane_sel_n, low_lane_sel_n, addr_latch_en},
                {!exp_wr, ~req_bytes, 1'h0});
        // Upper pins keep the address on an 8-bit bus, carry odd data on writes in evaluation mode
        if (strobe_n === 1'h0 && width_pin && !mode_reg[0])
            chk(upper_out, 8'h00);
        if (strobe_n === 1'h0 && mode_reg[0] && exp_wr)
            chk(upper_out, wd[15:8]);
    end
    // Ready low must stop the phase clock but not the clock output
    always @(posedge clk) begin
        #1;
        if (ready === 1'h0) chk({phase_clk, clk_out}, 2'h1);
    end
    initial begin
        for (int i = 0; i < 256; i++) shadow[i] = i[7:0] ^ 8'h5A;
        step(12);
        rst_b = 1'h1;
        chk({mode_reg, strobe_n, cycle_code_1, cycle_code_0, bus_busy}, {8'h02, 4'h8});
        access(1'h0, 1'h1, 8'h00, 2'h3, 1'h0);
        lat_int = lat;
        access(1'h0, 1'h0, 8'h10, 2'h3, 1'h1);
        chk(lat, lat_int + 1);
        chk(low_w, 2);
        for (int k = 0; k < 4; k++) begin
            wd = 16'($random(seed));
            access(1'h1, 1'h0, 8'h20 + 8'(2 * k), 2'h3, 1'h0);
            access(1'h0, 1'h0, 8'h20 + 8'(2 * k), 2'h3, 1'h1);
        end
        access(1'h0, 1'h0, 8'h31, 2'h2, 1'h0);
        access(1'h0, 1'h0, 8'h30, 2'h1, 1'h0);
        $display("test 16-bit bus done");
        wmode(8'h06);
        access(1'h0, 1'h0, 8'h40, 2'h3, 1'h1);
        chk(lat, lat_int);
        chk(low_w, 1);
        // An internal read ignores the pins, so the last external word stays put
        expq.push_back({shadow[8'h41], shadow[8'h40]});
        access(1'h0, 1'h1, 8'h00, 2'h3, 1'h0);
        chk(lat, lat_int);
        slow = 4'h3;
        access(1'h0, 1'h0, 8'h50, 2'h3, 1'h1);
        chk(lat, lat_int + 3);
        slow = 4'h0;
        width_pin = 1'h1;
        wd = 16'($random(seed));
        access(1'h1, 1'h0, 8'h60, 2'h3, 1'h0);
        access(1'h0, 1'h0, 8'h70, 2'h3, 1'h1);
        width_pin = 1'h0;
        access(1'h0, 1'h0, 8'h60, 2'h3, 1'h1);
        $display("test width and wait done");
        hold_req_n = 1'h0;
        wait_code(1'h1);
        chk(addr_lo_oe, 1'h1);
        step(1);
        chk({addr_lo_oe, upper_oe, lower_oe, ctl_oe}, 4'h0);
        hold_req_n = 1'h1;
        wait_code(1'h0);
        chk(addr_lo_oe, 1'h0);
        step(1);
        chk({addr_lo_oe, upper_oe, lower_oe, ctl_oe}, 4'hF);
        $display("test hold done");
        chk(port4_oe, 1'h0);
        mode_strap_pin = 1'h1;
        step(2);
        chk(port4_oe, 1'h1);
        mode_strap_pin = 1'h0;
        wmode(8'h03);
        chk(port4_oe, 1'h1);
        width_pin = 1'h1;
        access(1'h0, 1'h0, ebm_pkg::P4_DATA_ADDR[7:0], 2'h3, 1'h0);
        chk(lat, lat_int);
        access(1'h0, 1'h0, ebm_pkg::P4_DIR_ADDR[7:0], 2'h3, 1'h0);
        chk(lat, lat_int);
        access(1'h1, 1'h0, 8'h80, 2'h3, 1'h0);
        repeat (8) begin
            {flag_m, flag_x, using_x, cpu_queue_flush, cpu_data_access, cpu_first_opcode,
                cpu_opcode_read, debug_ctl_in} = 8'($random(seed));
            step(2);
            chk(port4_out, {1'h0, cpu_opcode_read, cpu_data_access | cpu_first_opcode,
                cpu_queue_flush, using_x ? flag_x : flag_m});
            chk(debug_ctl, debug_ctl_in);
        end
        $display("test evaluation mode done");
        close_out();
    end
endmodule : tb
`default_nettype wire
